// [verilog/twm_pkg.sv]
// constants, register map and field layout for the timer waveform mode control
// Summary of operation
// - nonzero channel A output mode hands the A pin to the compare output, except code 01 in PWM modes other than 9, 11, 14 and 15
// - nonzero channel B output mode hands the B pin to the compare output, except code 01 in any PWM mode
// - pin driver enabled only by its direction bit, whatever the output mode
// - meaning of an output mode code depends on the selected waveform mode
// - non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast PWM code 01 toggles only channel A, only in modes 14 and 15
// - fast PWM code 10 clears on match, sets at BOTTOM
// - fast PWM code 11 sets on match, clears at BOTTOM
// - fast PWM ignores a match at TOP with upper code bit set, BOTTOM action stays
// - dual-slope code 01 toggles only channel A, only in modes 9 and 11
// - dual-slope code 10 clears on up-count match, sets on down-count match
// - dual-slope code 11 sets on up-count match, clears on down-count match
// - waveform mode is two low bits of control A and two of control B
// - mode 0 uses TOP 0xFFFF, immediate updates, wrap flag at MAX
// - modes 4 and 12 take TOP from match A and capture, immediate, flag at MAX
// - modes 1-3 fixed TOP 0x00FF/0x01FF/0x03FF, load at TOP, flag at BOTTOM
// - modes 5-7 fixed 8/9/10-bit TOP, load at BOTTOM, flag at TOP
// - modes 8 and 9 TOP from capture and match A, load and flag at BOTTOM
// - modes 10 and 11 TOP from capture and match A, load at TOP, flag at BOTTOM
// - modes 14 and 15 TOP from capture and match A, load BOTTOM, flag TOP
// - dual-slope match equal to TOP with upper code bit set gets special handling
// - dual-slope counter runs up from zero to TOP and back down
// - upper waveform mode bits sit at bits 3 and 4 of control B
package twm_pkg;
  // ------------------------------------------------------------
  // register indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL_A    = 8'h80;
  localparam logic [7:0] IDX_CTRL_B    = 8'h81;
  localparam logic [7:0] IDX_COUNT     = 8'h84;
  localparam logic [7:0] IDX_CAPTURE   = 8'h86;
  localparam logic [7:0] IDX_MATCH_A   = 8'h88;
  localparam logic [7:0] IDX_MATCH_B   = 8'h8A;
  localparam logic [7:0] IDX_STATUS    = 8'h8C;
  localparam logic [7:0] IDX_PIN_DIR   = 8'h8D;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int CA_MODE_A_LSB = 6;
  localparam int CA_MODE_B_LSB = 4;
  localparam int CA_WAVE_LSB   = 0;
  localparam int CB_WAVE_LSB   = 3;
  localparam int CB_CLKSEL_LSB = 0;
  localparam int ST_WRAP       = 0;
  localparam int ST_MATCH_A    = 1;
  localparam int ST_MATCH_B    = 2;
  localparam logic [7:0]  CTRL_A_RST  = 8'h00;
  localparam logic [7:0]  CTRL_B_RST  = 8'h00;
  localparam logic [7:0]  CTRL_B_MASK = 8'hDF;
  localparam logic [15:0] WORD_RST    = 16'h0000;
  // ------------------------------------------------------------
  // counting limits and prescaler taps
  // ------------------------------------------------------------
  localparam logic [15:0] TOP_MAX   = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [9:0]  DIV_8     = 10'h007;
  localparam logic [9:0]  DIV_64    = 10'h03F;
  localparam logic [9:0]  DIV_256   = 10'h0FF;
  localparam logic [9:0]  DIV_1024  = 10'h3FF;
  // output mode codes
  localparam logic [1:0] OM_OFF    = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR  = 2'h2;
  localparam logic [1:0] OM_SET    = 2'h3;
  // waveform mode classes
  typedef enum logic [1:0] {
    TWM_CLASS_PLAIN = 2'b00,
    TWM_CLASS_FAST  = 2'b01,
    TWM_CLASS_DUAL  = 2'b11
  } twm_class_t;
endpackage : twm_pkg

// [verilog/twm_wave_ctrl.sv]
// 16-bit timer waveform mode decode, counter and compare pin control with APB access
`timescale 1ns/100ps
module twm_wave_ctrl
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        port_a_data,
  input  wire logic        port_b_data,
  output logic             chan_a_wave_pin,
  output logic             chan_a_wave_pin_oe,
  output logic             chan_b_wave_pin,
  output logic             chan_b_wave_pin_oe,
  output logic             wrap_flag
);
  import twm_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0]  ctrl_a_ff;
  logic [7:0]  ctrl_b_ff;
  logic [15:0] count_ff;
  logic [15:0] capture_ff;
  logic [15:0] match_a_buf_ff;
  logic [15:0] match_b_buf_ff;
  logic [15:0] match_a_ff;
  logic [15:0] match_b_ff;
  logic [2:0]  status_ff;
  logic [1:0]  pin_dir_ff;
  logic        up_ff;
  logic        block_ff;
  logic        oc_a_ff;
  logic        oc_b_ff;
  logic [9:0]  div_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        pin_a_ff;
  logic        pin_b_ff;
  logic        oe_a_ff;
  logic        oe_b_ff;

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  logic [3:0]  wave_select;
  logic [1:0]  chan_a_out_mode;
  logic [1:0]  chan_b_out_mode;
  twm_class_t  wclass;
  logic [15:0] top_value;
  logic        load_at_top;
  logic        immediate;

  assign wave_select     = {ctrl_b_ff[CB_WAVE_LSB+1 -: 2],
                            ctrl_a_ff[CA_WAVE_LSB+1 -: 2]};
  assign chan_a_out_mode = ctrl_a_ff[CA_MODE_A_LSB+1 -: 2];
  assign chan_b_out_mode = ctrl_a_ff[CA_MODE_B_LSB+1 -: 2];

  always_comb
  begin
    wclass      = TWM_CLASS_PLAIN;
    top_value   = TOP_MAX;
    load_at_top = 1'b0;
    immediate   = 1'b0;
    case (wave_select)
      4'h0:
      begin
        immediate = 1'b1;
      end
      4'h1, 4'h2, 4'h3:
      begin
        wclass      = TWM_CLASS_DUAL;
        load_at_top = 1'b1;
        top_value   = (wave_select == 4'h1) ? TOP_8BIT :
                      (wave_select == 4'h2) ? TOP_9BIT : TOP_10BIT;
      end
      4'h4, 4'hC:
      begin
        immediate = 1'b1;
        top_value = wave_select[3] ? capture_ff : match_a_ff;
      end
      4'h5, 4'h6, 4'h7:
      begin
        wclass    = TWM_CLASS_FAST;
        top_value = (wave_select == 4'h5) ? TOP_8BIT :
                    (wave_select == 4'h6) ? TOP_9BIT : TOP_10BIT;
      end
      4'h8, 4'h9:
      begin
        wclass    = TWM_CLASS_DUAL;
        top_value = wave_select[0] ? match_a_ff : capture_ff;
      end
      4'hA, 4'hB:
      begin
        wclass      = TWM_CLASS_DUAL;
        load_at_top = 1'b1;
        top_value   = wave_select[0] ? match_a_ff : capture_ff;
      end
      4'hE, 4'hF:
      begin
        wclass    = TWM_CLASS_FAST;
        top_value = wave_select[0] ? match_a_ff : capture_ff;
      end
      default:
      begin
        // reserved code 13 falls back to plain counting
        immediate = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // prescaler, one-cycle timer tick
  // ------------------------------------------------------------
  logic [9:0] div_limit;
  logic       tick;

  always_comb
  begin
    case (ctrl_b_ff[CB_CLKSEL_LSB+2 -: 3])
      3'h2:    div_limit = DIV_8;
      3'h3:    div_limit = DIV_64;
      3'h4:    div_limit = DIV_256;
      3'h5:    div_limit = DIV_1024;
      default: div_limit = 10'h000;
    endcase
  end

  // codes 0, 6 and 7 (stopped, external source) give no tick here
  assign tick = (ctrl_b_ff[2:0] != 3'h0) && (ctrl_b_ff[2:1] != 2'h3) && (div_ff == div_limit);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      div_ff <= 10'h000;
    else if (tick || ctrl_b_ff[2:0] == 3'h0)
      div_ff <= 10'h000;
    else
      div_ff <= div_ff + 10'h001;
  end

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic [7:0] idx;
  logic       acc;
  logic       wr;
  logic       mapped;
  logic [31:0] rd_mux;

  assign idx = paddr[9:2];
  assign acc = psel && penable && pready_ff;
  assign wr  = acc && pwrite && mapped;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (idx)
      IDX_CTRL_A:  rd_mux[7:0]  = ctrl_a_ff;
      IDX_CTRL_B:  rd_mux[7:0]  = ctrl_b_ff;
      IDX_COUNT:   rd_mux[15:0] = count_ff;
      IDX_CAPTURE: rd_mux[15:0] = capture_ff;
      IDX_MATCH_A: rd_mux[15:0] = match_a_buf_ff;
      IDX_MATCH_B: rd_mux[15:0] = match_b_buf_ff;
      IDX_STATUS:  rd_mux[2:0]  = status_ff;
      IDX_PIN_DIR: rd_mux[1:0]  = pin_dir_ff;
      default:     mapped       = 1'b0;
    endcase
  end

  // one wait state: pready rises in the second cycle of the access phase
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else if (psel && penable && !pready_ff)
    begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !mapped;
      prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
    end
    else
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_a_ff  <= CTRL_A_RST;
      ctrl_b_ff  <= CTRL_B_RST;
      capture_ff <= WORD_RST;
      pin_dir_ff <= 2'h0;
    end
    else if (wr)
    begin
      if (idx == IDX_CTRL_A)
        ctrl_a_ff <= pwdata[7:0] & 8'hF3;
      if (idx == IDX_CTRL_B)
        ctrl_b_ff <= pwdata[7:0] & CTRL_B_MASK;
      if (idx == IDX_CAPTURE)
        capture_ff <= pwdata[15:0];
      if (idx == IDX_PIN_DIR)
        pin_dir_ff <= pwdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  logic at_top;
  logic at_bottom;
  logic wrap_evt;
  logic load_evt;
  logic cnt_wr;

  assign cnt_wr    = wr && (idx == IDX_COUNT);
  assign at_top    = (count_ff == top_value);
  assign at_bottom = (count_ff == 16'h0000) && !up_ff;
  // single-slope: BOTTOM is the wrap after TOP; dual-slope: bottom turn
  assign load_evt  = tick && !immediate &&
                     (load_at_top ? at_top :
                      (wclass == TWM_CLASS_DUAL) ? at_bottom : at_top);
  always_comb
  begin
    case (wclass)
      TWM_CLASS_FAST: wrap_evt = tick && at_top;
      TWM_CLASS_DUAL: wrap_evt = tick && at_bottom;
      default:        wrap_evt = tick && (count_ff == TOP_MAX);
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count_ff <= WORD_RST;
      up_ff    <= 1'b1;
      block_ff <= 1'b0;
    end
    else if (cnt_wr)
    begin
      count_ff <= pwdata[15:0];
      block_ff <= 1'b1;
    end
    else if (tick)
    begin
      block_ff <= 1'b0;
      if (wclass == TWM_CLASS_DUAL)
      begin
        if (up_ff && at_top)
        begin
          up_ff    <= 1'b0;
          count_ff <= count_ff - 16'h0001;
        end
        else if (!up_ff && count_ff == 16'h0000)
        begin
          up_ff    <= 1'b1;
          count_ff <= 16'h0001;
        end
        else
          count_ff <= up_ff ? count_ff + 16'h0001 : count_ff - 16'h0001;
      end
      else
      begin
        up_ff    <= 1'b1;
        count_ff <= at_top ? 16'h0000 : count_ff + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // compare values, direct or double buffered
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      match_a_buf_ff <= WORD_RST;
      match_b_buf_ff <= WORD_RST;
      match_a_ff     <= WORD_RST;
      match_b_ff     <= WORD_RST;
    end
    else
    begin
      if (wr && idx == IDX_MATCH_A)
        match_a_buf_ff <= pwdata[15:0];
      if (wr && idx == IDX_MATCH_B)
        match_b_buf_ff <= pwdata[15:0];
      if (immediate)
      begin
        if (wr && idx == IDX_MATCH_A)
          match_a_ff <= pwdata[15:0];
        else
          match_a_ff <= match_a_buf_ff;
        if (wr && idx == IDX_MATCH_B)
          match_b_ff <= pwdata[15:0];
        else
          match_b_ff <= match_b_buf_ff;
      end
      else if (load_evt)
      begin
        match_a_ff <= match_a_buf_ff;
        match_b_ff <= match_b_buf_ff;
      end
    end
  end

  // ------------------------------------------------------------
  // compare output action per channel
  // ------------------------------------------------------------
  logic match_a;
  logic match_b;
  logic bottom_evt;
  logic conn_a;
  logic conn_b;
  logic toggle_ok;

  assign match_a    = tick && !block_ff && (count_ff == match_a_ff);
  assign match_b    = tick && !block_ff && (count_ff == match_b_ff);
  assign bottom_evt = tick && at_top;
  // code 01 in PWM modes only drives channel A, in modes 9, 11, 14 and 15
  assign toggle_ok  = (wclass == TWM_CLASS_FAST) ? (wave_select[3:1] == 3'h7) :
                      (wave_select == 4'h9 || wave_select == 4'hB);
  assign conn_a = (chan_a_out_mode != OM_OFF) &&
                  (wclass == TWM_CLASS_PLAIN || chan_a_out_mode != OM_TOGGLE || toggle_ok);
  assign conn_b = (chan_b_out_mode != OM_OFF) &&
                  (wclass == TWM_CLASS_PLAIN || chan_b_out_mode != OM_TOGGLE);

  // returns {change, value}; the same code acts differently per class
  function automatic logic [1:0] oc_step(input twm_class_t cls, input logic [1:0] om,
                                         input logic cur, input logic hit,
                                         input logic at_bot, input logic up,
                                         input logic cmp_top);
    logic [1:0] r;
    r = 2'b00;
    case (cls)
      TWM_CLASS_FAST:
      begin
        if (om == OM_TOGGLE && hit)
          r = {1'b1, !cur};
        else if (om[1] && hit && !cmp_top)
          r = {1'b1, om[0]};
        else if (om[1] && at_bot)
          r = {1'b1, !om[0]};
      end
      TWM_CLASS_DUAL:
      begin
        if (om == OM_TOGGLE && hit)
          r = {1'b1, !cur};
        else if (om[1] && hit && cmp_top)
          r = {1'b1, !om[0]};
        else if (om[1] && hit)
          r = {1'b1, up ? om[0] : !om[0]};
      end
      default:
      begin
        if (hit && om == OM_TOGGLE)
          r = {1'b1, !cur};
        else if (hit && om[1])
          r = {1'b1, om[0]};
      end
    endcase
    return r;
  endfunction : oc_step

  logic [1:0] step_a;
  logic [1:0] step_b;

  assign step_a = oc_step(wclass, chan_a_out_mode, oc_a_ff, match_a, bottom_evt, up_ff,
                          match_a_ff == top_value);
  assign step_b = oc_step(wclass, chan_b_out_mode, oc_b_ff, match_b, bottom_evt, up_ff,
                          match_b_ff == top_value);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      oc_a_ff <= 1'b0;
      oc_b_ff <= 1'b0;
    end
    else
    begin
      if (conn_a && step_a[1])
        oc_a_ff <= step_a[0];
      if (conn_b && step_b[1])
        oc_b_ff <= step_b[0];
    end
  end

  // ------------------------------------------------------------
  // status, set wins over a write-one clear
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      status_ff <= 3'h0;
    else
    begin
      status_ff[ST_WRAP] <= wrap_evt ||
        (status_ff[ST_WRAP] && !(wr && idx == IDX_STATUS && pwdata[ST_WRAP]));
      status_ff[ST_MATCH_A] <= match_a ||
        (status_ff[ST_MATCH_A] && !(wr && idx == IDX_STATUS && pwdata[ST_MATCH_A]));
      status_ff[ST_MATCH_B] <= match_b ||
        (status_ff[ST_MATCH_B] && !(wr && idx == IDX_STATUS && pwdata[ST_MATCH_B]));
    end
  end

  // ------------------------------------------------------------
  // pin mux; driver enable belongs to the direction bit alone
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pin_a_ff <= 1'b0;
      pin_b_ff <= 1'b0;
      oe_a_ff  <= 1'b0;
      oe_b_ff  <= 1'b0;
    end
    else
    begin
      pin_a_ff <= conn_a ? oc_a_ff : port_a_data;
      pin_b_ff <= conn_b ? oc_b_ff : port_b_data;
      oe_a_ff  <= pin_dir_ff[0];
      oe_b_ff  <= pin_dir_ff[1];
    end
  end

  assign chan_a_wave_pin    = pin_a_ff;
  assign chan_a_wave_pin_oe = oe_a_ff;
  assign chan_b_wave_pin    = pin_b_ff;
  assign chan_b_wave_pin_oe = oe_b_ff;
  assign wrap_flag          = status_ff[ST_WRAP];
  assign prdata             = prdata_ff;
  assign pready             = pready_ff;
  assign pslverr            = pslverr_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  plain_toggle_a: assert property (wclass == TWM_CLASS_PLAIN && conn_a && match_a &&
      chan_a_out_mode == OM_TOGGLE |=> oc_a_ff != $past(oc_a_ff))
    else $error("plain toggle missed");
  fast_bottom_a: assert property (wclass == TWM_CLASS_FAST && chan_a_out_mode == OM_CLEAR &&
      bottom_evt && !match_a |=> oc_a_ff)
    else $error("fast pwm bottom set missed");
  fast_inv_a: assert property (wclass == TWM_CLASS_FAST && chan_b_out_mode == OM_SET &&
      match_b && match_b_ff != top_value |=> oc_b_ff)
    else $error("inverting match set missed");
  fast_b_off_a: assert property (wclass != TWM_CLASS_PLAIN &&
      chan_b_out_mode == OM_TOGGLE |=> chan_b_wave_pin == $past(port_b_data))
    else $error("channel b toggle connected in pwm");
  dual_up_a: assert property (wclass == TWM_CLASS_DUAL && chan_a_out_mode == OM_CLEAR &&
      match_a && up_ff && match_a_ff != top_value |=> !oc_a_ff)
    else $error("dual up clear missed");
  dual_down_a: assert property (wclass == TWM_CLASS_DUAL && chan_a_out_mode == OM_SET &&
      match_a && !up_ff |=> !oc_a_ff)
    else $error("dual down clear missed");
  dual_range_a: assert property (wclass == TWM_CLASS_DUAL && tick && !cnt_wr &&
      !up_ff && count_ff == 16'h0000 |=> up_ff && count_ff == 16'h0001)
    else $error("dual bottom turn wrong");
  wrap_max_a: assert property (wave_select == 4'h0 && tick &&
      count_ff == TOP_MAX |=> wrap_flag)
    else $error("wrap flag not set at max");
  top_fixed_a: assert property (wave_select == 4'h2 && tick && !cnt_wr && up_ff &&
      count_ff == TOP_9BIT |=> !up_ff && count_ff == TOP_9BIT - 16'h0001)
    else $error("9-bit top wrong");
  pin_oe_a: assert property (pin_dir_ff == 2'h0 ##1 pin_dir_ff == 2'h0 |->
      !chan_a_wave_pin_oe && !chan_b_wave_pin_oe)
    else $error("pin driver enabled without direction");

  cov_fast_a: cover property (wclass == TWM_CLASS_FAST && conn_a && bottom_evt);
  cov_dual_a: cover property (wclass == TWM_CLASS_DUAL && conn_a && match_a && !up_ff);
  cov_wrap_a: cover property (wrap_evt ##1 wr && idx == IDX_STATUS);
  cov_err_a:  cover property (pslverr_ff);
endmodule : twm_wave_ctrl

// [bench/twm_wave_ctrl_tb_top.sv]
// self-checking bench for the timer waveform mode control
`timescale 1ns/100ps
module twm_wave_ctrl_tb_top;
  import twm_pkg::*;
  logic        mclk = 0;
  logic        rst = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [9:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, oe_a, oe_b, pin_a, pin_b, wrap, e;
  logic        pa = 0;
  logic        pb = 0;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          hi, tg;

  always #2.5 mclk = ~mclk;

  twm_wave_ctrl dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_a_data(pa), .port_b_data(pb), .chan_a_wave_pin(pin_a),
    .chan_a_wave_pin_oe(oe_a), .chan_b_wave_pin(pin_b), .chan_b_wave_pin_oe(oe_b),
    .wrap_flag(wrap));

  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_mismatch++;
      give_verdict;
    end
    else
    begin
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask : apb

  // stop, reprogram, restart, then let buffered values settle
  task setup(input logic [7:0] ca, input logic [7:0] cb, input logic [15:0] ma);
    apb(1, IDX_CTRL_B, 0);
    apb(1, IDX_CTRL_A, 32'(ca));
    apb(1, IDX_MATCH_A, 32'(ma));
    apb(1, IDX_COUNT, 0);
    apb(1, IDX_CTRL_B, 32'(cb));
    repeat (1100) @(posedge mclk);
  endtask : setup

  // high cycles and edges of pin a; pin b is forced high or follows port data
  task meas(input int n, input logic bset);
    logic p, b;
    hi = 0;
    tg = 0;
    p = pin_a;
    b = pb;
    repeat (n)
    begin
      @(posedge mclk);
      chk(pin_b, bset ? 1'b1 : b);
      hi += int'(pin_a);
      tg += int'(pin_a != p);
      p = pin_a;
      b = pb;
      pa <= 1'($urandom);
      pb <= 1'($urandom);
    end
  endtask : meas

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [31:0] v;
    int          top;
    void'($urandom(64320));
    repeat (5) @(posedge mclk);
    rst <= 0;
    apb(0, IDX_CTRL_A, 0);
    chk(q, 0);
    apb(0, IDX_CTRL_B, 0);
    chk(q, 0);
    apb(0, 8'h85, 0);
    chk(q, 0);
    chk(32'(e), 1);
    repeat (4)
    begin
      v = $urandom;
      apb(1, IDX_CTRL_A, v);
      apb(0, IDX_CTRL_A, 0);
      chk(q, v & 32'hF3);
      // reserved mode 13 stays unreachable whatever control A holds
      if (v[4:3] == 2'b11)
        v[3] = 1'b0;
      apb(1, IDX_CTRL_B, v);
      apb(0, IDX_CTRL_B, 0);
      chk(q, v & 32'(CTRL_B_MASK));
    end
    apb(1, IDX_PIN_DIR, 1);
    repeat (2) @(posedge mclk);
    chk({oe_a, oe_b}, 2'b10);
    apb(1, IDX_PIN_DIR, 2);
    repeat (2) @(posedge mclk);
    chk({oe_a, oe_b}, 2'b01);
    setup(8'h40, 8'h09, 16'h3);
    meas(40, 0);
    chk(tg, 10);
    setup(8'h80, 8'h09, 16'h3);
    meas(20, 0);
    chk(hi, 0);
    setup(8'hF0, 8'h09, 16'h3);
    meas(20, 1);
    chk(hi, 20);
    for (int md = 1; md <= 3; md++)
    begin
      top = (128 << md) - 1;
      setup(8'h80 | 8'(md), 8'h09, 16'h3F);
      meas(top + 1, 0);
      chk(hi, 64);
      setup(8'hC0 | 8'(md), 8'h09, 16'h3F);
      meas(top + 1, 0);
      chk(hi, top - 63);
      setup(8'h80 | 8'(md), 8'h01, 16'h40);
      meas(2 * top, 0);
      chk(hi, 128);
      setup(8'hC0 | 8'(md), 8'h01, 16'h40);
      meas(2 * top, 0);
      chk(hi, 2 * top - 128);
    end
    setup(8'h81, 8'h09, 16'hFF);
    meas(256, 0);
    chk(hi, 256);
    setup(8'h53, 8'h19, 16'h7);
    meas(80, 0);
    chk(tg, 10);
    setup(8'h83, 8'h11, 16'h20);
    meas(64, 0);
    chk(hi, 64);
    setup(8'h41, 8'h11, 16'h20);
    apb(1, IDX_STATUS, 1);
    meas(640, 0);
    chk(tg, 10);
    chk(wrap, 1);
    // capture value as TOP: toggle-on-match, fast, both dual-slope kinds
    apb(1, IDX_CAPTURE, 32'h20);
    setup(8'h40, 8'h19, 16'h10);
    meas(330, 0);
    chk(tg, 10);
    setup(8'h82, 8'h19, 16'h10);
    meas(33, 0);
    chk(hi, 17);
    setup(8'h80, 8'h11, 16'h10);
    meas(64, 0);
    chk(hi, 32);
    setup(8'h82, 8'h11, 16'h10);
    meas(64, 0);
    chk(hi, 32);
    // normal counting: wrap flag only once the count reaches MAX
    setup(8'h00, 8'h01, 16'h0);
    apb(1, IDX_STATUS, 1);
    @(posedge mclk);
    chk(wrap, 0);
    apb(1, IDX_COUNT, 32'hFFF0);
    repeat (20) @(posedge mclk);
    chk(wrap, 1);
    apb(1, IDX_CTRL_B, 0);
    apb(1, IDX_STATUS, 1);
    repeat (2) @(posedge mclk);
    chk(wrap, 0);
    give_verdict;
  end
endmodule : twm_wave_ctrl_tb_top
